// ==== sar_sync.sv ====
// Shared constants and a two-flop input synchroniser for the converter control
package sar_pkg;
  localparam int RES_BITS = 12;
  localparam int CLK_MHZ = 25;
  localparam int CONV_NS_J = 6000;
  localparam int CONV_NS_K = 4500;
  localparam int CONV_NS_L = 3000;
  localparam int CONVERT_MIN_NS = 200;
  localparam int CONVERT_MIN_CYC = (CONVERT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int STEP_MARGIN_CYC = 4;
  localparam int SYNC_STEP_MIN_CYC = 3;
  localparam logic [1:0] SHORT_12 = 2'h0;
  localparam logic [1:0] SHORT_10 = 2'h1;
  localparam logic [1:0] SHORT_8 = 2'h2;
  localparam logic [3:0] LAST_12 = 4'h0;
  localparam logic [3:0] LAST_10 = 4'h2;
  localparam logic [3:0] LAST_8 = 4'h4;
  localparam logic [3:0] TOP_IDX = 4'hB;
  localparam logic [11:0] RESULT_RST = 12'h000;
  typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_TRIAL, ST_DONE, ST_WAIT} conv_state_t;
endpackage : sar_pkg

`timescale 1ns/1ps
module sar_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  initial begin
    if (WIDTH < 1) $error("sar_sync width must be at least one");
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : sar_sync

// ==== sar_adc_conversion_control.sv ====
// Conversion sequencing, bit trials and parallel/serial result of the converter
`timescale 1ns/1ps
module sar_adc_conversion_control #(
  parameter int CONV_NS = sar_pkg::CONV_NS_L,
  parameter int STEP_CYC = (CONV_NS * sar_pkg::CLK_MHZ / 1000 - sar_pkg::STEP_MARGIN_CYC)
                           / sar_pkg::RES_BITS
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic convert,
  input wire logic comp_in,
  input wire logic ext_clk,
  input wire logic ext_clk_mode,
  input wire logic [1:0] short_sel,
  input wire logic bipolar,
  input wire logic twos_comp,
  input wire logic serial_invert,
  output logic eoc,
  output logic [11:0] result,
  output logic [11:0] approximation_register,
  output logic serial_out
);
  localparam int CNT_W = 8;

  logic convert_s;
  logic comp_s;
  logic ext_clk_s;
  logic convert_d_ff;
  logic ext_clk_d_ff;
  sar_pkg::conv_state_t state_ff, nxt_state;
  logic [11:0] trial_ff, nxt_trial;
  logic [11:0] result_ff, nxt_result;
  logic [3:0] idx_ff, nxt_idx;
  logic [CNT_W-1:0] step_cnt_ff, nxt_step_cnt;
  logic serial_ff, nxt_serial;
  logic convert_rise;
  logic convert_fall;
  logic ext_rise;
  logic step;
  logic bit_keep;
  logic [3:0] last_idx;

  // Comparator answer needs two sync flops and one settled cycle before each decision
  initial begin
    if (STEP_CYC < sar_pkg::SYNC_STEP_MIN_CYC || STEP_CYC >= (1 << CNT_W)) begin
      $error("STEP_CYC out of range");
    end
  end

  // Convert, comparator and external clock pins cross into the clock domain through two flops each
  sar_sync #(.WIDTH(3)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in({convert, comp_in, ext_clk}),
    .sync_out({convert_s, comp_s, ext_clk_s})
  );

  function automatic logic [3:0] last_bit(input logic [1:0] sel);
    case (sel)
      sar_pkg::SHORT_10: last_bit = sar_pkg::LAST_10;
      sar_pkg::SHORT_8: last_bit = sar_pkg::LAST_8;
      default: last_bit = sar_pkg::LAST_12;
    endcase
  endfunction : last_bit

  assign convert_rise = convert_s && !convert_d_ff;
  assign convert_fall = !convert_s && convert_d_ff;
  assign ext_rise = ext_clk_s && !ext_clk_d_ff;
  assign last_idx = last_bit(short_sel);
  // Internal timing paces the trials; external mode steps on each clock rise
  assign step = ext_clk_mode ? ext_rise : (step_cnt_ff == CNT_W'(STEP_CYC - 1));
  assign bit_keep = comp_s; // Comparator high means trial level is not above the input

  always_comb begin
    nxt_state = state_ff;
    nxt_trial = trial_ff;
    nxt_result = result_ff;
    nxt_idx = idx_ff;
    nxt_serial = serial_ff;
    nxt_step_cnt = (step_cnt_ff == CNT_W'(STEP_CYC - 1)) ? '0 : step_cnt_ff + 1'b1;
    case (state_ff)
      sar_pkg::ST_IDLE, sar_pkg::ST_DONE, sar_pkg::ST_WAIT: begin
        if (convert_rise) begin
          nxt_state = sar_pkg::ST_ARMED;
          nxt_trial = '0;
          nxt_result = sar_pkg::RESULT_RST;
          nxt_serial = 1'b0;
        end else if (state_ff == sar_pkg::ST_DONE) begin
          // Continuous string only when convert already went back low in external mode
          nxt_state = ext_clk_mode ? sar_pkg::ST_WAIT : sar_pkg::ST_IDLE;
        end else if (state_ff == sar_pkg::ST_WAIT && ext_rise) begin
          nxt_state = sar_pkg::ST_TRIAL;
          nxt_trial = '0;
          nxt_trial[sar_pkg::TOP_IDX] = 1'b1;
          nxt_idx = sar_pkg::TOP_IDX;
        end
      end
      sar_pkg::ST_ARMED: begin
        // Holding convert high keeps the register reset and aligns the start
        nxt_step_cnt = '0;
        if (convert_fall) begin
          nxt_state = sar_pkg::ST_TRIAL;
          nxt_trial = '0;
          nxt_trial[sar_pkg::TOP_IDX] = 1'b1;
          nxt_idx = sar_pkg::TOP_IDX;
        end
      end
      sar_pkg::ST_TRIAL: begin
        if (convert_rise) begin
          nxt_state = sar_pkg::ST_ARMED;
          nxt_trial = '0;
          nxt_result = sar_pkg::RESULT_RST;
        end else if (step) begin
          nxt_trial[idx_ff] = bit_keep;
          nxt_serial = bit_keep ^ serial_invert;
          if (idx_ff == last_idx) begin
            nxt_state = sar_pkg::ST_DONE;
            nxt_result = {nxt_trial[11] ^ (bipolar && twos_comp), nxt_trial[10:0]};
          end else begin
            nxt_idx = idx_ff - 1'b1;
            nxt_trial[idx_ff - 1'b1] = 1'b1;
          end
        end
      end
      default: nxt_state = sar_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= sar_pkg::ST_IDLE;
      trial_ff <= '0;
      result_ff <= sar_pkg::RESULT_RST;
      idx_ff <= sar_pkg::TOP_IDX;
      serial_ff <= 1'b0;
      step_cnt_ff <= '0;
      convert_d_ff <= 1'b0;
      ext_clk_d_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      trial_ff <= nxt_trial;
      result_ff <= nxt_result;
      idx_ff <= nxt_idx;
      serial_ff <= nxt_serial;
      step_cnt_ff <= nxt_step_cnt;
      convert_d_ff <= convert_s;
      ext_clk_d_ff <= ext_clk_s;
    end
  end

  // Busy covers the armed phase too, so a sample-hold is in hold before trials start
  // Done keeps busy one more cycle, so the result is settled before eoc falls
  assign eoc = (state_ff == sar_pkg::ST_ARMED) || (state_ff == sar_pkg::ST_TRIAL)
               || (state_ff == sar_pkg::ST_DONE);
  assign result = result_ff;
  assign approximation_register = trial_ff;
  assign serial_out = serial_ff;

  // Helper: cycles spent in trials of one conversion
  logic [CNT_W+3:0] conv_cnt_ff;
  always_ff @(posedge clock) begin
    if (sys_rst || state_ff != sar_pkg::ST_TRIAL) conv_cnt_ff <= '0;
    else conv_cnt_ff <= conv_cnt_ff + 1'b1;
  end

  busy_in_trial_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == sar_pkg::ST_TRIAL) |-> eoc)
    else $error("eoc low during trials");
  conv_time_a: assert property (@(posedge clock) disable iff (sys_rst)
    !ext_clk_mode |-> conv_cnt_ff <= (CNT_W+4)'(CONV_NS * sar_pkg::CLK_MHZ / 1000))
    else $error("conversion exceeds grade time");
  rise_clears_a: assert property (@(posedge clock) disable iff (sys_rst)
    convert_rise |=> (result == 12'h000 && approximation_register == 12'h000))
    else $error("convert rise did not clear outputs");
  fall_starts_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == sar_pkg::ST_ARMED && convert_fall) |=> (state_ff == sar_pkg::ST_TRIAL
      && approximation_register == 12'h800))
    else $error("conversion did not start on convert fall");
  result_valid_a: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(eoc) && $past(state_ff) == sar_pkg::ST_DONE |->
      result[10:0] == approximation_register[10:0])
    else $error("result not valid at eoc fall");
  twos_top_a: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(eoc) && $past(state_ff) == sar_pkg::ST_DONE |->
      result[11] == (approximation_register[11] ^ $past(bipolar && twos_comp, 2)))
    else $error("top bit coding wrong");
  short_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == sar_pkg::ST_DONE && short_sel == sar_pkg::SHORT_8) |->
      approximation_register[3:0] == 4'h0)
    else $error("short cycle left low bits set");
  serial_bit_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == sar_pkg::ST_TRIAL && step && !convert_rise) |=>
      serial_out == ($past(comp_s) ^ $past(serial_invert)))
    else $error("serial bit does not follow decision");
  one_bit_step_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == sar_pkg::ST_TRIAL && step && !convert_rise && idx_ff != last_idx) |=>
      idx_ff == $past(idx_ff) - 4'h1)
    else $error("trial index did not advance by one");
  cont_start_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == sar_pkg::ST_WAIT && ext_rise && !convert_rise) |=>
      (eoc && approximation_register == 12'h800))
    else $error("continuous conversion did not restart");
  result_held_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == sar_pkg::ST_DONE && !convert_rise) |=> (!eoc && $stable(result)))
    else $error("result moved as eoc fell");
  busy_on_rise_a: assert property (@(posedge clock) disable iff (sys_rst)
    convert_rise |=> eoc)
    else $error("eoc not high after convert rise");
  short_ten_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == sar_pkg::ST_DONE && short_sel == sar_pkg::SHORT_10) |->
      approximation_register[1:0] == 2'h0)
    else $error("ten-bit cycle left low bits set");
  serial_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == sar_pkg::ST_TRIAL && !step && !convert_rise) |=>
      $stable(serial_out))
    else $error("serial bit changed between decisions");
endmodule : sar_adc_conversion_control

// ==== sar_host_model.sv ====
// Host-side model: comparator front end and capture of the result at completion
`timescale 1ns/1ps
module sar_host_model (
  input wire logic [11:0] approximation_register,
  input wire logic eoc,
  input wire logic [11:0] result,
  input wire logic [11:0] level,
  output logic comp_in,
  output logic [11:0] captured
);
  // Ideal comparator, so any wrong code comes from the trial logic
  assign comp_in = (approximation_register <= level);
  // Latch right on the fall, as external capture logic would
  always @(negedge eoc) begin
    captured = result;
  end
endmodule : sar_host_model

// ==== sar_adc_conversion_control_tb.sv ====
// Self-checking bench for the converter control
`timescale 1ns/1ps
module sar_adc_conversion_control_tb;
  localparam int STEP = 3;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic convert = 1'b0;
  logic ext_clk = 1'b0;
  logic ext_clk_mode = 1'b0;
  logic [1:0] short_sel = 2'h0;
  logic bipolar = 1'b0;
  logic twos_comp = 1'b0;
  logic serial_invert = 1'b0;
  logic [11:0] level = 12'h000;
  logic comp_in, eoc, serial_out;
  logic [11:0] result, approximation_register, captured;
  int num_errors = 0;
  int checked = 0;
  always #20 clock = ~clock;
  sar_adc_conversion_control #(.STEP_CYC(STEP)) u_dut (.clock(clock), .sys_rst(sys_rst),
    .convert(convert), .comp_in(comp_in), .ext_clk(ext_clk), .ext_clk_mode(ext_clk_mode),
    .short_sel(short_sel), .bipolar(bipolar), .twos_comp(twos_comp),
    .serial_invert(serial_invert), .eoc(eoc), .result(result),
    .approximation_register(approximation_register), .serial_out(serial_out));
  sar_host_model u_host (.approximation_register(approximation_register), .eoc(eoc),
    .result(result), .level(level), .comp_in(comp_in), .captured(captured));
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : step
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_eoc(input logic v, input int lim, output int n);
    n = 0;
    while (eoc !== v && n < lim) begin
      step(1);
      n++;
    end
    check({11'h000, eoc}, {11'h000, v});
  endtask : wait_eoc
  task automatic conclude;
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // Endpoints, mid-scale pair and both short-cycle lengths, with coding options
  task automatic t_codes;
    logic [11:0] lv [6] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'hA5C, 12'h3C7};
    logic [1:0] sl [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
    logic [11:0] exp;
    logic tc;
    int bits, n;
    for (int i = 0; i < 6; i++) begin
      bits = 12 - 2 * sl[i];
      tc = (i == 3 || i == 5);
      level = lv[i];
      short_sel = sl[i];
      bipolar = tc || i == 4;
      twos_comp = tc;
      serial_invert = (i % 2 == 0);
      exp = lv[i] & (12'hFFF << (12 - bits));
      convert = 1'b1;
      step(6);
      check(result, 12'h000);
      check({11'h000, eoc}, 12'h001);
      convert = 1'b0;
      wait_eoc(1'b0, 200, n);
      check({11'h000, n >= bits * STEP && n <= bits * STEP + 6}, 12'h001);
      check(result, exp ^ {tc, 11'h000});
      check(captured, exp ^ {tc, 11'h000});
      check({11'h000, serial_out}, {11'h000, exp[12 - bits] ^ serial_invert});
      step(2);
    end
  endtask : t_codes
  // A short pulse in external-clock mode must restart by itself after completion
  task automatic t_cont;
    int n;
    ext_clk_mode = 1'b1;
    level = 12'h5A3;
    short_sel = 2'h0;
    bipolar = 1'b0;
    twos_comp = 1'b0;
    fork
      repeat (400) begin
        step(3);
        ext_clk = ~ext_clk;
      end
      begin
        convert = 1'b1;
        step(6);
        convert = 1'b0;
        wait_eoc(1'b0, 300, n);
        check(result, 12'h5A3);
        wait_eoc(1'b1, 100, n);
        wait_eoc(1'b0, 300, n);
        check(captured, 12'h5A3);
      end
    join
    ext_clk_mode = 1'b0;
  endtask : t_cont
  initial begin
    step(5);
    sys_rst = 1'b0;
    check(result, 12'h000);
    check({11'h000, eoc}, 12'h000);
    step(1);
    t_codes();
    t_cont();
    conclude();
  end
  // Whole run is near 1500 cycles, so this limit only trips on a hang
  initial begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule : sar_adc_conversion_control_tb
